/* File: core/hpw_ctrl.sv */
`timescale 1ns/1ps
// Contract
// R1 - both keep-alive low: deepest sleep, only watchdog
// R2 - low keep-alive only: stop fast clock
// R3 - both keep-alive high: both clocks run
// R4 - high keep-alive only: stop slow clock
// R5 - halt program, preserve memory and registers
// R6 - hold I/O pins as at halt
// R7 - halt sets power-down, clears timeout flag
// R8 - halt clears watchdog, keeps it counting
// R9 - wake on pin edge, interrupt, watchdog
// R10 - power-down clears only on power-up, clear-watchdog
// R11 - watchdog wake: set timeout, reset pc/sp
// R12 - per-pin Port A wake enable
// R13 - pin wake resumes after halt
// R14 - masked or stack-full irq stays pending
// R15 - oscillator restarts and settles before execution
// R16 - enabled irq with stack room serviced
// R17 - irq pending before halt cannot wake
// R18 - slow internal oscillator always runs
// R19 - enable bit 1 wakes, 0 ignores
module hpw_ctrl
  import hpw_pkg::*;
#(
  parameter int PORT_W    = hpw_pkg::HPW_PORT_W,
  parameter int START_CYC = hpw_pkg::HPW_OSC_START_CYC
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic              halt_i,
  input  wire logic              clr_wdt_i,
  input  wire logic              hs_osc_idle_keepalive_i,
  input  wire logic              ls_osc_idle_keepalive_i,
  input  wire logic [PORT_W-1:0] port_a_wake_enable_i,
  input  wire logic [PORT_W-1:0] port_a_pin_i,
  input  wire logic              irq_req_i,
  input  wire logic              irq_enabled_i,
  input  wire logic              stack_full_i,
  input  wire logic              wdt_overflow_i,
  input  wire logic              hs_osc_stable_i,
  output logic                   cpu_run_o,
  output logic                   hs_clk_en_o,
  output logic                   ls_clk_en_o,
  output logic                   low_speed_internal_osc_en_o,
  output logic                   io_hold_o,
  output logic                   power_down_flag_o,
  output logic                   watchdog_timeout_flag_o,
  output logic                   wdt_clear_o,
  output logic                   pc_sp_reset_o,
  output logic                   irq_service_o,
  output logic                   irq_leave_pending_o,
  output logic [2:0]             mode_o
);
  import hpw_pkg::*;

  if (PORT_W < 1 || START_CYC < 1) begin : g_bad_params
    $error("hpw_ctrl: bad parameters");
  end

  localparam int CW = $clog2(START_CYC + 1);

  hpw_state_t  state_q;
  hpw_cause_t  cause_q;
  logic        irq_armed_q;
  logic [CW-1:0] cnt_q;
  logic        pin_fall;
  logic        irq_wake;
  logic        asleep;
  logic        wake_ev;

  hpw_edge_det #(.W(PORT_W)) u_edge (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .pin_i    (port_a_pin_i),
    .enable_i (port_a_wake_enable_i),
    .fall_o   (pin_fall)
  );

  assign asleep   = (state_q != HPW_RUN) && (state_q != HPW_WAKE);
  assign irq_wake = irq_req_i & irq_armed_q; // R17
  assign wake_ev  = pin_fall | irq_wake | wdt_overflow_i; // R9

  // irq already asserted at halt is disarmed until it drops
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_armed_q <= 1'b0;
    end else if (state_q == HPW_RUN && halt_i) begin
      irq_armed_q <= ~irq_req_i; // R17
    end else if (!irq_req_i) begin
      irq_armed_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= HPW_RUN;
      cause_q <= HPW_CAUSE_NONE;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        HPW_RUN: begin
          if (halt_i) begin
            unique case ({hs_osc_idle_keepalive_i, ls_osc_idle_keepalive_i})
              2'b00: state_q <= HPW_SLEEP; // R1
              2'b01: state_q <= HPW_IDLE_LOW; // R2
              2'b11: state_q <= HPW_IDLE_BOTH; // R3
              2'b10: state_q <= HPW_IDLE_HIGH; // R4
            endcase
          end
        end
        HPW_SLEEP, HPW_IDLE_LOW, HPW_IDLE_BOTH, HPW_IDLE_HIGH: begin
          // watchdog wins over irq, irq over pin
          if (wake_ev) begin
            state_q <= HPW_WAKE;
            cnt_q   <= '0;
            if (wdt_overflow_i) begin
              cause_q <= HPW_CAUSE_WDT;
            end else if (irq_wake) begin
              cause_q <= HPW_CAUSE_IRQ;
            end else begin
              cause_q <= HPW_CAUSE_PIN;
            end
          end
        end
        HPW_WAKE: begin
          // settle count starts once the fast oscillator says stable
          if (hs_osc_stable_i) begin
            if (cnt_q >= CW'(START_CYC - 1)) begin
              state_q <= HPW_RUN; // R15
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_run_o   <= 1'b1;
      io_hold_o   <= 1'b0;
      hs_clk_en_o <= 1'b1;
      ls_clk_en_o <= 1'b1;
      mode_o      <= 3'h0;
    end else begin
      cpu_run_o   <= (state_q == HPW_RUN) && !halt_i; // R5
      io_hold_o   <= asleep || (state_q == HPW_RUN && halt_i); // R6
      hs_clk_en_o <= (state_q == HPW_RUN) || (state_q == HPW_WAKE) ||
                     (state_q == HPW_IDLE_BOTH) || (state_q == HPW_IDLE_HIGH); // R1 R2 R3 R4
      ls_clk_en_o <= (state_q == HPW_RUN) || (state_q == HPW_WAKE) ||
                     (state_q == HPW_IDLE_BOTH) || (state_q == HPW_IDLE_LOW); // R1 R2 R3 R4
      mode_o      <= 3'(state_q);
    end
  end

  // watchdog needs the slow oscillator in every mode
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      low_speed_internal_osc_en_o <= 1'b1;
    end else begin
      low_speed_internal_osc_en_o <= 1'b1; // R18
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      power_down_flag_o <= HPW_PDF_RST;
    end else if (state_q == HPW_RUN && halt_i) begin
      power_down_flag_o <= 1'b1; // R7
    end else if (clr_wdt_i && state_q == HPW_RUN) begin
      power_down_flag_o <= 1'b0; // R10
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      watchdog_timeout_flag_o <= HPW_TO_RST;
    end else if (asleep && wdt_overflow_i) begin
      watchdog_timeout_flag_o <= 1'b1; // R11
    end else if (state_q == HPW_RUN && halt_i) begin
      watchdog_timeout_flag_o <= 1'b0; // R7
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wdt_clear_o         <= 1'b0;
      pc_sp_reset_o       <= 1'b0;
      irq_service_o       <= 1'b0;
      irq_leave_pending_o <= 1'b0;
    end else begin
      wdt_clear_o <= state_q == HPW_RUN && halt_i; // R8
      pc_sp_reset_o <= 1'b0;
      irq_service_o <= 1'b0;
      irq_leave_pending_o <= 1'b0;
      if (state_q == HPW_WAKE && hs_osc_stable_i && cnt_q >= CW'(START_CYC - 1)) begin
        // pin wake needs no pulse: cpu just resumes after halt
        unique case (cause_q)
          HPW_CAUSE_WDT: pc_sp_reset_o <= 1'b1; // R11
          HPW_CAUSE_IRQ: begin
            irq_service_o       <= irq_enabled_i & ~stack_full_i; // R16
            irq_leave_pending_o <= ~irq_enabled_i | stack_full_i; // R14
          end
          HPW_CAUSE_PIN, HPW_CAUSE_NONE: ; // R13
        endcase
      end
    end
  end

  chk_halt_sets_flags: assert property (@(posedge mclk_i) disable iff (rst_i) // R7
    (state_q == HPW_RUN && halt_i) |=> power_down_flag_o && !watchdog_timeout_flag_o)
    else $error("halt flags wrong");
  chk_halt_clears_wdt: assert property (@(posedge mclk_i) disable iff (rst_i) // R8
    (state_q == HPW_RUN && halt_i) |=> wdt_clear_o)
    else $error("no watchdog clear on halt");
  chk_sleep_clocks_off: assert property (@(posedge mclk_i) disable iff (rst_i) // R1
    (state_q == HPW_RUN && halt_i && !hs_osc_idle_keepalive_i && !ls_osc_idle_keepalive_i)
    |=> ##1 !hs_clk_en_o && !ls_clk_en_o && low_speed_internal_osc_en_o)
    else $error("sleep clocks wrong");
  chk_idle_low_clk: assert property (@(posedge mclk_i) disable iff (rst_i) // R2
    (state_q == HPW_IDLE_LOW) |=> !hs_clk_en_o && ls_clk_en_o)
    else $error("idle low clocks wrong");
  chk_idle_both_clk: assert property (@(posedge mclk_i) disable iff (rst_i) // R3
    (state_q == HPW_IDLE_BOTH) |=> hs_clk_en_o && ls_clk_en_o && !cpu_run_o)
    else $error("idle both clocks wrong");
  chk_idle_high_clk: assert property (@(posedge mclk_i) disable iff (rst_i) // R4
    (state_q == HPW_IDLE_HIGH) |=> hs_clk_en_o && !ls_clk_en_o)
    else $error("idle high clocks wrong");
  chk_io_held_sleep: assert property (@(posedge mclk_i) disable iff (rst_i) // R6
    asleep |=> io_hold_o && !cpu_run_o)
    else $error("io not held");
  chk_pdf_sticky: assert property (@(posedge mclk_i) disable iff (rst_i) // R10
    $fell(power_down_flag_o) |-> $past(clr_wdt_i))
    else $error("pdf cleared without clear-watchdog");
  chk_wdt_wake_to: assert property (@(posedge mclk_i) disable iff (rst_i) // R11
    (asleep && wdt_overflow_i) |=> watchdog_timeout_flag_o && state_q == HPW_WAKE)
    else $error("watchdog wake wrong");
  chk_stale_irq: assert property (@(posedge mclk_i) disable iff (rst_i) // R17
    (asleep && !irq_armed_q && !pin_fall && !wdt_overflow_i) |=> asleep)
    else $error("stale irq woke device");
  chk_pin_wake_edge: assert property (@(posedge mclk_i) disable iff (rst_i) // R9
    (asleep && pin_fall) |=> state_q == HPW_WAKE)
    else $error("pin edge did not wake");
  chk_resume_waits_osc: assert property (@(posedge mclk_i) disable iff (rst_i) // R15
    (state_q == HPW_WAKE && !hs_osc_stable_i) |=> state_q == HPW_WAKE && !cpu_run_o)
    else $error("resumed before oscillator stable");
endmodule : hpw_ctrl

/* File: pkg/hpw_pkg.sv */
package hpw_pkg;

  typedef enum logic [2:0] {
    HPW_RUN,
    HPW_SLEEP,
    HPW_IDLE_LOW,
    HPW_IDLE_BOTH,
    HPW_IDLE_HIGH,
    HPW_WAKE
  } hpw_state_t;

  typedef enum logic [1:0] {
    HPW_CAUSE_NONE,
    HPW_CAUSE_PIN,
    HPW_CAUSE_IRQ,
    HPW_CAUSE_WDT
  } hpw_cause_t;

  localparam int  HPW_PORT_W       = 8;
  localparam int  HPW_CLK_MHZ      = 25;
  localparam int  HPW_OSC_START_US = 1;
  localparam int  HPW_OSC_START_CYC = HPW_OSC_START_US * HPW_CLK_MHZ;
  localparam logic HPW_PDF_RST     = 1'b0;
  localparam logic HPW_TO_RST      = 1'b0;

endpackage : hpw_pkg

/* File: core/hpw_edge_det.sv */
`timescale 1ns/1ps
// per-pin falling edge detect, gated by wake enable
module hpw_edge_det #(
  parameter int W = 8
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] pin_i,
  input  wire logic [W-1:0] enable_i,
  output logic              fall_o
);
  logic [W-1:0] prev_q;
  logic [W-1:0] hit;

  // reset high: pins power up as inputs with pull-high
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_q <= '1;
    end else begin
      prev_q <= pin_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_pin
      assign hit[g] = enable_i[g] & prev_q[g] & ~pin_i[g]; // R12 R19
    end
  endgenerate

  assign fall_o = |hit;
endmodule : hpw_edge_det

/* File: verif/hpw_osc_model.sv */
`timescale 1ns/1ps
// fast oscillator: unstable while gated, settles SETTLE+1 cycles after re-enable
module hpw_osc_model #(
  parameter int SETTLE = 3
) (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic hs_clk_en_i,
  output logic      hs_osc_stable_o
);
  int on_cnt;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      on_cnt          <= SETTLE;
      hs_osc_stable_o <= 1'b1;
    end else if (!hs_clk_en_i) begin
      on_cnt          <= 0;
      hs_osc_stable_o <= 1'b0;
    end else begin
      if (on_cnt < SETTLE) begin
        on_cnt <= on_cnt + 1;
      end
      hs_osc_stable_o <= (on_cnt >= SETTLE);
    end
  end
endmodule : hpw_osc_model

/* File: verif/tb_hpw_ctrl.sv */
`timescale 1ns/1ps
module tb_hpw_ctrl;
  import hpw_pkg::*;
  logic       mclk_i, rst_i, halt, clr_wdt, hs_ka, ls_ka, irq_req, irq_en, stk_full, wdt_ovf;
  logic       stable, cpu_run_o, hs_clk_en_o, ls_clk_en_o, lsi_en_o, io_hold_o, pdf_o, to_o;
  logic       wdt_clear_o, pc_sp_reset_o, irq_service_o, irq_leave_pending_o;
  logic [7:0] wake_en, pin_a;
  logic [2:0] mode_o, prev_mode;
  logic [2:0] pulse_seen;
  logic [3:0] exp_q[$];
  logic [2:0] md_tab[4] = '{3'h1, 3'h2, 3'h4, 3'h3};
  int         bad_count, check_count;

  hpw_ctrl #(.PORT_W(8), .START_CYC(2)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .halt_i(halt),
    .clr_wdt_i(clr_wdt), .hs_osc_idle_keepalive_i(hs_ka), .ls_osc_idle_keepalive_i(ls_ka),
    .port_a_wake_enable_i(wake_en), .port_a_pin_i(pin_a), .irq_req_i(irq_req),
    .irq_enabled_i(irq_en), .stack_full_i(stk_full), .wdt_overflow_i(wdt_ovf),
    .hs_osc_stable_i(stable), .cpu_run_o(cpu_run_o), .hs_clk_en_o(hs_clk_en_o),
    .ls_clk_en_o(ls_clk_en_o), .low_speed_internal_osc_en_o(lsi_en_o), .io_hold_o(io_hold_o),
    .power_down_flag_o(pdf_o), .watchdog_timeout_flag_o(to_o), .wdt_clear_o(wdt_clear_o),
    .pc_sp_reset_o(pc_sp_reset_o), .irq_service_o(irq_service_o),
    .irq_leave_pending_o(irq_leave_pending_o), .mode_o(mode_o));
  hpw_osc_model #(.SETTLE(3)) osc (.mclk_i(mclk_i), .rst_i(rst_i), .hs_clk_en_i(hs_clk_en_o),
    .hs_osc_stable_o(stable));

  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  // resume: pulses stand one cycle before mode shows run, so keep last cycle's
  always @(negedge mclk_i) begin
    if (!rst_i && prev_mode === 3'h5 && mode_o === 3'h0) begin
      if (exp_q.size() == 0)
        check(8'hff, 8'h00);
      else
        check({4'h0, pulse_seen, to_o},
              {4'h0, exp_q.pop_front()});
      check({5'h0, pc_sp_reset_o, irq_service_o, irq_leave_pending_o}, 8'h00);
    end
    prev_mode  = mode_o;
    pulse_seen = {pc_sp_reset_o, irq_service_o, irq_leave_pending_o};
  end

  // cause: 0 watchdog, 1 irq served, 2 irq masked, 3 stack full, 4 pin
  task automatic nap(input int key, input int cause);
    int b;
    int d;
    int n;
    hs_ka <= key[1];
    ls_ka <= key[0];
    halt  <= 1'b1;
    @(negedge mclk_i);
    halt <= 1'b0;
    // mode code lags the state by one edge, so it still shows run here
    check({cpu_run_o, io_hold_o, pdf_o, to_o, wdt_clear_o, mode_o},
          {5'b01101, 3'h0});
    @(negedge mclk_i);
    check({2'h0, mode_o, hs_clk_en_o, ls_clk_en_o, lsi_en_o},
          {2'h0, md_tab[key], key[1], key[0], 1'b1});
    b = $urandom % 8;
    d = (b + 1) % 8;
    wake_en <= ($urandom | (8'h1 << b)) & ~(8'h1 << d);
    // a disabled pin falling first: must not wake
    if (cause == 4) pin_a <= ~(8'h1 << d);
    repeat (4) @(negedge mclk_i);
    check({7'h0, cpu_run_o}, 8'h00);
    case (cause)
      0: begin
        wdt_ovf <= 1'b1;
        exp_q.push_back(4'b1001);
        @(negedge mclk_i);
        wdt_ovf <= 1'b0;
      end
      4: begin
        pin_a <= ~(8'h1 << d) & ~(8'h1 << b);
        exp_q.push_back(4'b0000);
      end
      default: begin
        irq_en   <= (cause != 2);
        stk_full <= (cause == 3);
        irq_req  <= 1'b1;
        exp_q.push_back(cause == 1 ? 4'b0100 : 4'b0010);
      end
    endcase
    n = 0;
    while (cpu_run_o !== 1'b1 && n < 200) begin
      @(negedge mclk_i);
      n++;
    end
    if (cpu_run_o !== 1'b1) begin
      bad_count++;
      results();
    end
    check({7'h0, pdf_o}, 8'h01);
    irq_req <= 1'b0;
    pin_a   <= 8'hff;
    repeat (2) @(negedge mclk_i);
  endtask : nap

  initial begin
    {halt, clr_wdt, hs_ka, ls_ka, irq_req, irq_en, stk_full, wdt_ovf} = 8'h00;
    wake_en     = 8'h00;
    pin_a       = 8'hff;
    rst_i       = 1'b1;
    bad_count   = 0;
    check_count = 0;
    void'($urandom(32'he537b710));
    repeat (2) @(negedge mclk_i);
    rst_i <= 1'b0;
    @(negedge mclk_i);
    check({cpu_run_o, pdf_o, to_o, 2'b00, mode_o}, 8'h80);
    for (int i = 0; i < 10; i++)
      nap(i % 4, i % 5);
    // request already high at halt: only the watchdog may end the nap
    irq_en  <= 1'b1;
    irq_req <= 1'b1;
    nap(0, 0);
    clr_wdt <= 1'b1;
    @(negedge mclk_i);
    clr_wdt <= 1'b0;
    @(negedge mclk_i);
    check({7'h0, pdf_o}, 8'h00);
    check(8'(exp_q.size()), 8'h00);
    results();
  end
endmodule : tb_hpw_ctrl
